// [verilog/gpio_pkg.sv]
// constants, register map and carrier types for the gpio port block
//
// What this block does
// - an enabled group 0 pin that changes level sets the group 0 flag
// - a group flag clears on vector entry or on a one written to it
// - a group interrupt fires only with flag, group enable and global enable
// - group 2 mask holds eight read/write bits for pins 23..16, reset zero
// - group 1 mask has seven bits for pins 14..8; bit 7 reads zero
// - group 0 mask holds eight read/write bits for pins 7..0, reset zero
// - each port has output data, direction and read-only input pin registers
// - a one written to an input pin bit inverts that output data bit
// - global pull-up disable switches off every pull-up on every port
// - direction one makes the pin an output, zero an input
// - pull-up on only for direction 0, data 1 and pull-ups allowed
// - all pins go high impedance as soon as reset is active
// - an output pin drives the data bit level, never with pull-up
// - single-bit set or clear changes only the addressed pin
// - one pin's alternate use leaves the other pins of the port alone
// - input pins read the synchronised pin level whatever the direction
// - each group enable with global enable lets its pins raise interrupt
`default_nettype none
package gpio_pkg;
  localparam int NUM_PORTS = 3;
  localparam int NUM_GROUPS = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // port register block: three consecutive locations per port
  localparam logic [7:0] PORT_BASE = 8'h20;
  localparam logic [7:0] PORT_STRIDE = 8'h03;
  localparam logic [7:0] OFS_INPUT = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h01;
  localparam logic [7:0] OFS_OUT = 8'h02;
  // pin change registers
  localparam logic [7:0] ADDR_CHANGE_FLAG = 8'h3C;
  localparam logic [7:0] ADDR_CHANGE_CTRL = 8'h68;
  localparam logic [7:0] ADDR_MASK0 = 8'h6B;
  localparam logic [7:0] ADDR_MASK1 = 8'h6C;
  localparam logic [7:0] ADDR_MASK2 = 8'h6D;
  localparam logic [7:0] MASK1_VALID = 8'h7F;
  // core control register holding the global pull-up disable
  localparam logic [7:0] ADDR_CORE_CTRL = 8'h35;
  localparam int PUD_BIT = 4;

  // one access on the processor's i/o register port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] wmask;
  } io_req_t;
endpackage
`default_nettype wire

// [verilog/pin_sync.sv]
// three-stage synchroniser with agreement filter for eight pins
`default_nettype none
module pin_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] pin_i,
  output logic [7:0] level_o
);
  logic [7:0] s1_q, s2_q, s3_q, lvl_q;
  logic [7:0] s1_d, s2_d, s3_d, lvl_d;

  // first stage feeds only the second; a level counts once stages agree
  always_comb begin
    s1_d = pin_i;
    s2_d = s1_q;
    s3_d = s2_q;
    lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_q <= gpio_pkg::RESET_BYTE;
      s2_q <= gpio_pkg::RESET_BYTE;
      s3_q <= gpio_pkg::RESET_BYTE;
      lvl_q <= gpio_pkg::RESET_BYTE;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;
endmodule
`default_nettype wire

// [verilog/change_group.sv]
// pin change detector and sticky flag for one group of eight pins
`default_nettype none
module change_group (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] level_i,
  input wire logic [7:0] mask_i,
  input wire logic enable_i,
  input wire logic clear_i,
  input wire logic ack_i,
  output logic flag_o
);
  logic [7:0] prev_q, prev_d;
  logic flag_q, flag_d;
  logic request;

  // compare against last cycle's sample; only masked pins count
  always_comb begin
    prev_d = level_i;
    request = enable_i & (|((level_i ^ prev_q) & mask_i));
    // a change in the clearing cycle still sets the flag
    flag_d = request | (flag_q & ~(clear_i | ack_i));
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      prev_q <= gpio_pkg::RESET_BYTE;
      flag_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;
endmodule
`default_nettype wire

// [verilog/gpio_port_with_pin_change_masks.sv]
// three 8-bit gpio ports with pin change masks, flags and group interrupts
`default_nettype none
module gpio_port_with_pin_change_masks (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire gpio_pkg::io_req_t io_req_i,
  output logic [7:0] io_rdata_o,
  input wire logic global_int_enable_i,
  input wire logic [2:0] vector_ack_i,
  input wire logic [23:0] pad_i,
  output logic [23:0] pad_o,
  output logic [23:0] pad_oe_o,
  output logic [23:0] pullup_en_o,
  output logic [2:0] change_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // address of one register of one port
  function automatic logic [7:0] port_addr(input int k,
                                           input logic [7:0] ofs);
    logic [7:0] idx;
    idx = 8'(k);
    port_addr = 8'(gpio_pkg::PORT_BASE + idx * gpio_pkg::PORT_STRIDE + ofs);
  endfunction

  // merge only the bits selected by the write mask
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input logic [7:0] data,
                                       input logic [7:0] mask);
    merge = (old & ~mask) | (data & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [2:0][7:0] out_q, out_d;
  logic [2:0][7:0] dir_q, dir_d;
  logic [2:0][7:0] mask_q, mask_d;
  logic [2:0] ctrl_q, ctrl_d;
  logic pud_q, pud_d;
  logic [7:0] rdata_q, rdata_d;
  logic [23:0] pad_q, pad_d;
  logic [23:0] oe_q, oe_d;
  logic [23:0] pu_q, pu_d;
  logic [2:0] irq_q, irq_d;
  logic [2:0] flag_clr;
  logic [2:0] flags;
  logic [2:0][7:0] level;
  logic wr, rd;
  logic [7:0] addr, wdata, wmask;

  assign wr = io_req_i.wr;
  assign rd = io_req_i.rd;
  assign addr = io_req_i.addr;
  assign wdata = io_req_i.wdata;
  assign wmask = io_req_i.wmask;

  ////////////////////////////////////////////////////////////////////////////
  // per-port synchronisers and per-group change detectors

  // each pin has its own slice, so one pin's use never disturbs another
  for (genvar k = 0; k < gpio_pkg::NUM_PORTS; k++) begin : g_port
    pin_sync u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(pad_i[k*8 +: 8]),
      .level_o(level[k])
    );
  end

  for (genvar g = 0; g < gpio_pkg::NUM_GROUPS; g++) begin : g_group
    change_group u_group (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .level_i(level[g]),
      .mask_i(mask_q[g]),
      .enable_i(ctrl_q[g]),
      .clear_i(flag_clr[g]),
      .ack_i(vector_ack_i[g]),
      .flag_o(flags[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  // byte-wide writes honour the bit mask, so a one-bit set or clear
  // issued by the processor touches that pin alone
  always_comb begin
    out_d = out_q;
    dir_d = dir_q;
    mask_d = mask_q;
    ctrl_d = ctrl_q;
    pud_d = pud_q;
    flag_clr = 3'h0;
    if (wr) begin
      for (int k = 0; k < gpio_pkg::NUM_PORTS; k++) begin
        if (addr == port_addr(k, gpio_pkg::OFS_DIR)) begin
          dir_d[k] = merge(dir_q[k], wdata, wmask);
        end
        if (addr == port_addr(k, gpio_pkg::OFS_OUT)) begin
          out_d[k] = merge(out_q[k], wdata, wmask);
        end
        if (addr == port_addr(k, gpio_pkg::OFS_INPUT)) begin
          // ones invert the data bit, zeros leave it, direction ignored
          out_d[k] = out_q[k] ^ (wdata & wmask);
        end
      end
      case (addr)
        gpio_pkg::ADDR_MASK0: begin
          mask_d[0] = merge(mask_q[0], wdata, wmask);
        end
        gpio_pkg::ADDR_MASK1: begin
          // top bit is reserved and stays zero
          mask_d[1] = merge(mask_q[1], wdata, wmask)
                      & gpio_pkg::MASK1_VALID;
        end
        gpio_pkg::ADDR_MASK2: begin
          mask_d[2] = merge(mask_q[2], wdata, wmask);
        end
        gpio_pkg::ADDR_CHANGE_CTRL: begin
          ctrl_d = 3'(merge({5'h00, ctrl_q}, wdata, wmask));
        end
        gpio_pkg::ADDR_CHANGE_FLAG: begin
          flag_clr = 3'(wdata & wmask);
        end
        gpio_pkg::ADDR_CORE_CTRL: begin
          if (wmask[gpio_pkg::PUD_BIT]) begin
            pud_d = wdata[gpio_pkg::PUD_BIT];
          end
        end
        default: begin
          flag_clr = 3'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads

  // read data appears one cycle after the request; unmapped reads give zero
  always_comb begin
    rdata_d = rdata_q;
    if (rd) begin
      rdata_d = 8'h00;
      for (int k = 0; k < gpio_pkg::NUM_PORTS; k++) begin
        if (addr == port_addr(k, gpio_pkg::OFS_INPUT)) begin
          rdata_d = level[k];
        end
        if (addr == port_addr(k, gpio_pkg::OFS_DIR)) begin
          rdata_d = dir_q[k];
        end
        if (addr == port_addr(k, gpio_pkg::OFS_OUT)) begin
          rdata_d = out_q[k];
        end
      end
      case (addr)
        gpio_pkg::ADDR_MASK0: rdata_d = mask_q[0];
        gpio_pkg::ADDR_MASK1: rdata_d = mask_q[1] & gpio_pkg::MASK1_VALID;
        gpio_pkg::ADDR_MASK2: rdata_d = mask_q[2];
        gpio_pkg::ADDR_CHANGE_CTRL: rdata_d = {5'h00, ctrl_q};
        gpio_pkg::ADDR_CHANGE_FLAG: rdata_d = {5'h00, flags};
        gpio_pkg::ADDR_CORE_CTRL: begin
          rdata_d = 8'h00;
          rdata_d[gpio_pkg::PUD_BIT] = pud_q;
        end
        default: begin
          rdata_d = rdata_d;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers and interrupt outputs

  // pins follow the register values that are being stored this edge
  always_comb begin
    for (int k = 0; k < gpio_pkg::NUM_PORTS; k++) begin
      for (int n = 0; n < 8; n++) begin
        oe_d[k*8+n] = dir_d[k][n];
        pad_d[k*8+n] = out_d[k][n];
        // pull-up only on an input with data one and pull-ups allowed
        pu_d[k*8+n] = ~dir_d[k][n] & out_d[k][n] & ~pud_d;
      end
    end
    for (int g = 0; g < gpio_pkg::NUM_GROUPS; g++) begin
      irq_d[g] = flags[g] & ctrl_q[g] & global_int_enable_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int k = 0; k < gpio_pkg::NUM_PORTS; k++) begin
        out_q[k] <= gpio_pkg::RESET_BYTE;
        dir_q[k] <= gpio_pkg::RESET_BYTE;
        mask_q[k] <= gpio_pkg::RESET_BYTE;
      end
      ctrl_q <= 3'h0;
      pud_q <= 1'b0;
      rdata_q <= gpio_pkg::RESET_BYTE;
      pad_q <= 24'h000000;
      oe_q <= 24'h000000;
      pu_q <= 24'h000000;
      irq_q <= 3'h0;
    end else begin
      out_q <= out_d;
      dir_q <= dir_d;
      mask_q <= mask_d;
      ctrl_q <= ctrl_d;
      pud_q <= pud_d;
      rdata_q <= rdata_d;
      pad_q <= pad_d;
      oe_q <= oe_d;
      pu_q <= pu_d;
      irq_q <= irq_d;
    end
  end

  // the reset level gates the drivers directly, so pins float at once
  // even with the clock stopped; pad_oe_o and pullup_en_o are the two outputs not purely a flop
  assign pad_oe_o = oe_q & {24{rst_n_i}};
  assign pullup_en_o = pu_q & {24{rst_n_i}};
  assign pad_o = pad_q;
  assign io_rdata_o = rdata_q;
  assign change_irq_o = irq_q;

endmodule
`default_nettype wire

// [bench/gpio_port_monitor.sv]
// concurrent checks on the ports of the gpio port top module
`default_nettype none
module gpio_port_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire gpio_pkg::io_req_t io_req_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic global_int_enable_i,
  input wire logic [2:0] vector_ack_i,
  input wire logic [23:0] pad_i,
  input wire logic [23:0] pad_o,
  input wire logic [23:0] pad_oe_o,
  input wire logic [23:0] pullup_en_o,
  input wire logic [2:0] change_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic full_wr;
  // whole-byte writes only, so bit-masked writes never trip these
  assign full_wr = io_req_i.wr && io_req_i.wmask == 8'hFF;
  ////////////////////////////////////////////////////////////////////////
  AST_RST_HIZ: assert property (disable iff (1'b0)
    !rst_n_i |-> !pad_oe_o && !pullup_en_o) else $error("pins on in reset");
  AST_ZERO: assert property ($rose(rst_n_i) |-> !pad_oe_o && !pullup_en_o)
    else $error("pins on after reset");
  AST_EXCL: assert property (!(pad_oe_o & pullup_en_o))
    else $error("pull-up on driven pin");
  AST_GIE: assert property (!global_int_enable_i |=> !change_irq_o)
    else $error("irq without global enable");
  AST_MASK1: assert property (io_req_i.rd && io_req_i.addr ==
    gpio_pkg::ADDR_MASK1 |=> !io_rdata_o[7]) else $error("mask1 bit7 set");
  AST_UNMAP: assert property (io_req_i.rd && io_req_i.addr == 8'h00
    |=> io_rdata_o == 8'h00) else $error("unmapped read nonzero");
  AST_DIR: assert property (full_wr && io_req_i.addr ==
    gpio_pkg::PORT_BASE + gpio_pkg::OFS_DIR |=>
    pad_oe_o[7:0] == $past(io_req_i.wdata)) else $error("dir not applied");
  AST_TOGGLE: assert property (full_wr && io_req_i.addr ==
    gpio_pkg::PORT_BASE && pad_oe_o[7:0] == 8'hFF |=>
    pad_o[7:0] == ($past(pad_o[7:0]) ^ $past(io_req_i.wdata)))
    else $error("toggle wrong");
  AST_PUD: assert property (full_wr && io_req_i.addr ==
    gpio_pkg::ADDR_CORE_CTRL && io_req_i.wdata[gpio_pkg::PUD_BIT]
    |=> !pullup_en_o) else $error("pull-up not disabled");
  cover property (|change_irq_o);
  cover property (|pullup_en_o);
  cover property (full_wr && io_req_i.addr == gpio_pkg::PORT_BASE);
endmodule
bind gpio_port_with_pin_change_masks gpio_port_monitor mon_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .io_req_i(io_req_i),
  .io_rdata_o(io_rdata_o), .global_int_enable_i(global_int_enable_i),
  .vector_ack_i(vector_ack_i), .pad_i(pad_i), .pad_o(pad_o),
  .pad_oe_o(pad_oe_o), .pullup_en_o(pullup_en_o),
  .change_irq_o(change_irq_o));
`default_nettype wire

// [bench/pad_board.sv]
// board model resolving the package pins of the three ports
`default_nettype none
module pad_board (
  input wire logic clk_i,
  input wire logic [23:0] pad_o,
  input wire logic [23:0] pad_oe_o,
  input wire logic [23:0] pullup_en_o,
  input wire logic [23:0] ext_en_i,
  input wire logic [23:0] ext_val_i,
  output logic [23:0] pad_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] float_q = 24'h0;
  // floating pins wander every cycle so a stale level never passes
  always @(posedge clk_i) float_q <= ~float_q;
  // device drive wins, board drive beats the weak pull-up
  always_comb begin
    pad_i = float_q;
    for (int i = 0; i < 24; i++) begin
      if (pad_oe_o[i]) pad_i[i] = pad_o[i];
      else if (ext_en_i[i]) pad_i[i] = ext_val_i[i];
      else if (pullup_en_o[i]) pad_i[i] = 1'b1;
    end
  end
endmodule
`default_nettype wire

// [bench/gpio_port_with_pin_change_masks_tb.sv]
// self-checking bench for the gpio port with pin change masks
`default_nettype none
module gpio_port_with_pin_change_masks_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  gpio_pkg::io_req_t req = '0;
  logic gie = 1'b0;
  logic [2:0] ack = 3'h0;
  logic [23:0] ext_en = 24'h0;
  logic [23:0] ext_val = 24'h0;
  logic [23:0] pad_i, pad_o, pad_oe_o, pullup_en_o;
  logic [7:0] rdata, r, d, o, t;
  logic [2:0] irq;
  int bad_count = 0;
  int check_count = 0;
  gpio_port_with_pin_change_masks dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .io_req_i(req), .io_rdata_o(rdata), .global_int_enable_i(gie),
    .vector_ack_i(ack), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe_o(pad_oe_o), .pullup_en_o(pullup_en_o), .change_irq_o(irq));
  pad_board board_u (.clk_i(clk_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o),
    .pullup_en_o(pullup_en_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .pad_i(pad_i));
  initial forever #50 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  // helpers: compare, bus cycles, expectations
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [7:0] m);
    @(posedge clk_i);
    #10 req = '{1'b1, 1'b0, a, v, m};
    @(posedge clk_i);
    #10 req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    #10 req = '{1'b0, 1'b1, a, 8'h00, 8'h00};
    @(posedge clk_i);
    #10 req.rd = 1'b0;
    v = rdata;
  endtask
  // bounded wait, the level is judged once the edge has settled
  task automatic wait_irq(input int g, input logic v);
    for (int i = 0; i < 12 && irq[g] !== v; i++) @(posedge clk_i);
    #10 chk("irq", irq[g], v);
  endtask
  function automatic logic [7:0] pa(input int k, input logic [7:0] ofs);
    return 8'(gpio_pkg::PORT_BASE + gpio_pkg::PORT_STRIDE * k + ofs);
  endfunction
  function automatic logic [7:0] pull_exp(input logic [7:0] dd, oo);
    return ~dd & oo;
  endfunction
  task automatic print_verdict();
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // a hang counts as a mismatch
  initial begin
    #(20000 * 100);
    bad_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'h9050ACDE));
    #10 chk("oe_rst", pad_oe_o[7:0] | pad_oe_o[23:16], 8'h00);
    repeat (20) @(posedge clk_i);
    #10 rst_n_i = 1'b1;
    ext_en = 24'hFFFFFF;
    // reset values, mask read/write and the reserved mask bit
    for (int k = 0; k < 3; k++) begin
      rd(pa(k, gpio_pkg::OFS_DIR), r);
      chk("dir_rst", r, 8'h00);
      rd(gpio_pkg::ADDR_MASK0 + 8'(k), r);
      chk("mask_rst", r, 8'h00);
      t = 8'($urandom);
      wr(gpio_pkg::ADDR_MASK0 + 8'(k), t, 8'hFF);
      rd(gpio_pkg::ADDR_MASK0 + 8'(k), r);
      chk("mask_rw", r, k == 1 ? t & 8'h7F : t);
    end
    rd(8'h00, r);
    chk("unmapped", r, 8'h00);
    // random pin setups; data before direction keeps legal transitions
    for (int n = 0; n < 12; n++) begin
      int k;
      k = n % 3;
      d = n == 0 ? 8'hFF : 8'($urandom);
      o = 8'($urandom);
      ext_val[k*8 +: 8] = 8'($urandom);
      wr(pa(k, gpio_pkg::OFS_OUT), o, 8'hFF);
      wr(pa(k, gpio_pkg::OFS_DIR), d, 8'hFF);
      chk("oe", pad_oe_o[k*8 +: 8], d);
      chk("drive", pad_o[k*8 +: 8] & d, o & d);
      chk("pullup", pullup_en_o[k*8 +: 8], pull_exp(d, o));
      t = 8'($urandom);
      wr(pa(k, gpio_pkg::OFS_INPUT), t, 8'hFF);
      rd(pa(k, gpio_pkg::OFS_OUT), r);
      chk("toggle", r, o ^ t);
      repeat (5) @(posedge clk_i);
      rd(pa(k, gpio_pkg::OFS_INPUT), r);
      chk("pins", r, d & (o ^ t) | ~d & ext_val[k*8 +: 8]);
      wr(pa(k, gpio_pkg::OFS_DIR), 8'hFF, 8'h01 << k);
      chk("bitset", pad_oe_o[k*8 +: 8], d | 8'h01 << k);
      wr(gpio_pkg::ADDR_CORE_CTRL, 8'(1 << gpio_pkg::PUD_BIT), 8'hFF);
      chk("pud", pullup_en_o[k*8 +: 8], 8'h00);
      wr(gpio_pkg::ADDR_CORE_CTRL, 8'h00, 8'hFF);
      wr(pa(k, gpio_pkg::OFS_OUT), 8'h00, 8'hFF);
      wr(pa(k, gpio_pkg::OFS_DIR), 8'h00, 8'hFF);
    end
    // pin change per group: masking, flag clear, global enable, vector
    gie = 1'b1;
    for (int g = 0; g < 3; g++) begin
      wr(gpio_pkg::ADDR_MASK0 + 8'(g), 8'h01, 8'hFF);
      wr(gpio_pkg::ADDR_CHANGE_CTRL, 8'(1 << g), 8'hFF);
      ext_val[g*8+1] = ~ext_val[g*8+1];
      repeat (8) @(posedge clk_i);
      #10 chk("masked", irq[g], 1'b0);
      ext_val[g*8] = ~ext_val[g*8];
      wait_irq(g, 1'b1);
      wr(gpio_pkg::ADDR_CHANGE_FLAG, 8'h00, 8'hFF);
      chk("hold", irq[g], 1'b1);
      wr(gpio_pkg::ADDR_CHANGE_FLAG, 8'(1 << g), 8'hFF);
      wait_irq(g, 1'b0);
      gie = 1'b0;
      ext_val[g*8] = ~ext_val[g*8];
      repeat (8) @(posedge clk_i);
      #10 chk("gie_off", irq[g], 1'b0);
      gie = 1'b1;
      wait_irq(g, 1'b1);
      ack[g] = 1'b1;
      @(posedge clk_i);
      #10 ack = 3'h0;
      wait_irq(g, 1'b0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
